//--- rtl/dlic_top.sv
// Dual-line interrupt controller: register port, source sampling, two lines
//
// Our own choices: the register offsets and strobed register access.
module dlic_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [dlic_pkg::ADDR_W-1:0] addr,
    input wire logic [dlic_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [dlic_pkg::DATA_W-1:0] rd_data,
    input wire logic [dlic_pkg::SRC_HI:dlic_pkg::SRC_LO] peripheral_irq,
    input wire logic external_request_pin_zero,
    input wire logic external_request_pin_one,
    output logic normal_request_line,
    output logic fast_request_line
);
    import dlic_pkg::*;

    function automatic dlic_sel_type decode_addr(input logic [ADDR_W-1:0] a);
        dlic_sel_type s;
        case (a)
            OFF_NORMAL_RAW: s = SEL_NORMAL_RAW;
            OFF_NORMAL_EN: s = SEL_NORMAL_EN;
            OFF_NORMAL_CLR: s = SEL_NORMAL_CLR;
            OFF_NORMAL_STA: s = SEL_NORMAL_STA;
            OFF_FAST_RAW: s = SEL_FAST_RAW;
            OFF_FAST_EN: s = SEL_FAST_EN;
            OFF_FAST_CLR: s = SEL_FAST_CLR;
            OFF_FAST_STA: s = SEL_FAST_STA;
            OFF_SW_CFG: s = SEL_SW_CFG;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode_addr

    dlic_sel_type wr_sel;
    dlic_sel_type rd_sel;
    logic [DATA_W-1:0] src_next;
    logic [DATA_W-1:0] src_reg;
    logic [DATA_W-1:0] swcfg_reg;
    logic [DATA_W-1:0] rd_next;
    logic [LINES-1:0] set_we;
    logic [LINES-1:0] clr_we;
    logic [LINES-1:0] soft_int_bit;
    logic [LINES-1:0] req;
    logic [DATA_W-1:0] mask [LINES];
    logic [DATA_W-1:0] raw [LINES];
    logic [DATA_W-1:0] status [LINES];

    assign wr_sel = decode_addr(addr);
    assign rd_sel = decode_addr(addr);

    // Write strobes into each line's enable bank
    always_comb begin
        set_we = '0;
        clr_we = '0;
        if (wr_en) begin
            set_we[0] = (wr_sel == SEL_NORMAL_EN);
            set_we[1] = (wr_sel == SEL_FAST_EN);
            clr_we[0] = (wr_sel == SEL_NORMAL_CLR);
            clr_we[1] = (wr_sel == SEL_FAST_CLR);
        end
    end

    // Gather peripheral and pin sources into line bit positions
    always_comb begin
        src_next = SRC_RST;
        src_next[SRC_HI:SRC_LO] = peripheral_irq;
        src_next[BIT_XPIN0] = peripheral_irq[BIT_XPIN0] | external_request_pin_zero;
        src_next[BIT_XPIN1] = peripheral_irq[BIT_XPIN1] | external_request_pin_one;
    end

    // Level sources caught every cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            src_reg <= SRC_RST;
        end else begin
            src_reg <= src_next;
        end
    end

    // Software interrupt configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            swcfg_reg <= SWCFG_RST;
        end else if (wr_en && wr_sel == SEL_SW_CFG) begin
            swcfg_reg <= wr_data & SWCFG_MASK;
        end
    end

    assign soft_int_bit[0] = swcfg_reg[SWCFG_NORMAL_BIT];
    assign soft_int_bit[1] = swcfg_reg[SWCFG_FAST_BIT];

    // One mask bank and one status path per line; line 0 normal, 1 fast
    for (genvar g = 0; g < LINES; g++) begin : g_line
        localparam int OTHER = LINES - 1 - g;

        dlic_mask_bank u_mask (
            .clk(clk),
            .srst(srst),
            .set_we(set_we[g]),
            .clr_we(clr_we[g]),
            .cross_we(set_we[OTHER]),
            .wr_data(wr_data),
            .mask_reg(mask[g])
        );

        dlic_line_status u_status (
            .clk(clk),
            .srst(srst),
            .src(src_reg),
            .soft_int(soft_int_bit[g]),
            .mask(mask[g]),
            .raw(raw[g]),
            .status(status[g]),
            .request_reg(req[g])
        );
    end

    assign normal_request_line = req[0];
    assign fast_request_line = req[1];

    // Read data for the cycle after the strobe; zero otherwise
    always_comb begin
        rd_next = RD_RST;
        if (rd_en) begin
            case (rd_sel)
                SEL_NORMAL_RAW: begin
                    rd_next = raw[0];
                end
                SEL_NORMAL_EN: begin
                    rd_next = mask[0];
                end
                SEL_NORMAL_STA: begin
                    rd_next = status[0];
                end
                SEL_FAST_RAW: begin
                    rd_next = raw[1];
                end
                SEL_FAST_EN: begin
                    rd_next = mask[1];
                end
                SEL_FAST_STA: begin
                    rd_next = status[1];
                end
                SEL_SW_CFG: begin
                    rd_next = swcfg_reg;
                end
                default: begin
                    rd_next = RD_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= RD_RST;
        end else begin
            rd_data <= rd_next;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_mask_exclusive: assert property ((mask[0] & mask[1]) == '0)
        else $error("source enabled on both lines");

    a_soft_bit_inert: assert property (
        !mask[0][BIT_SOFT_INT] && !mask[1][BIT_SOFT_INT] && !mask[0][BIT_ALL] && !mask[1][BIT_ALL])
        else $error("enable bit 0 or 1 became set");

    a_mask_hold: assert property (
        !wr_en |=> mask[0] == $past(mask[0]) && mask[1] == $past(mask[1]))
        else $error("enable mask changed without a write");

    a_normal_clear: assert property (
        wr_en && wr_sel == SEL_NORMAL_CLR |=> mask[0] == ($past(mask[0]) & ~$past(wr_data)))
        else $error("normal mask clear wrong");

    a_fast_clear: assert property (
        wr_en && wr_sel == SEL_FAST_CLR |=> mask[1] == ($past(mask[1]) & ~$past(wr_data)))
        else $error("fast mask clear wrong");

    a_clear_other_line: assert property (
        wr_en && wr_sel == SEL_NORMAL_CLR |=> mask[1] == $past(mask[1]))
        else $error("normal clear touched fast mask");

    a_fast_set_cross: assert property (
        wr_en && wr_sel == SEL_FAST_EN |=>
        ((mask[1] & $past(wr_data) & SRC_MASK) == ($past(wr_data) & SRC_MASK))
        && ((mask[0] & $past(wr_data)) == '0))
        else $error("fast enable side effect wrong");

    a_normal_set_cross: assert property (
        wr_en && wr_sel == SEL_NORMAL_EN |=>
        ((mask[0] & $past(wr_data) & SRC_MASK) == ($past(wr_data) & SRC_MASK))
        && ((mask[1] & $past(wr_data)) == '0))
        else $error("normal enable side effect wrong");

    a_set_keeps_rest: assert property (
        wr_en && wr_sel == SEL_NORMAL_EN |=>
        (mask[0] & ~$past(wr_data)) == ($past(mask[0]) & ~$past(wr_data)))
        else $error("normal enable write changed unwritten bits");

    a_pin_zero_raw: assert property (
        external_request_pin_zero |=> raw[0][BIT_XPIN0] && raw[1][BIT_XPIN0])
        else $error("pin zero not in raw");

    a_pin_one_raw: assert property (
        external_request_pin_one |=> raw[0][BIT_XPIN1] && raw[1][BIT_XPIN1])
        else $error("pin one not in raw");

    a_raw_follows: assert property (
        raw[0][SRC_HI:SRC_LO] == $past(src_next[SRC_HI:SRC_LO]))
        else $error("raw not sampled source");

    a_raw_top_zero: assert property (
        raw[0][DATA_W-1:SRC_HI+1] == '0 && raw[1][DATA_W-1:SRC_HI+1] == '0)
        else $error("unused raw bits set");

    a_normal_status_bits: assert property (
        status[0][SRC_HI:SRC_LO] == (raw[0][SRC_HI:SRC_LO] & mask[0][SRC_HI:SRC_LO]))
        else $error("normal status not raw and enable");

    a_fast_status_bits: assert property (
        status[1][SRC_HI:SRC_LO] == (raw[1][SRC_HI:SRC_LO] & mask[1][SRC_HI:SRC_LO]))
        else $error("fast status not raw and enable");

    a_timer_req: assert property (
        peripheral_irq[BIT_TIMER0] && mask[0][BIT_TIMER0] && $stable(mask[0]) && !wr_en
        |=> ##1 normal_request_line)
        else $error("enabled timer did not raise normal line");

    a_pin_fast_req: assert property (
        external_request_pin_zero && mask[1][BIT_XPIN0] && !wr_en
        |=> ##1 fast_request_line)
        else $error("enabled pin zero did not raise fast line");

    a_normal_line: assert property (
        normal_request_line == $past(|status[0]))
        else $error("normal line not OR of status");

    a_normal_bit0: assert property (
        status[0][BIT_ALL] == (|status[0][DATA_W-1:1]) && raw[0][BIT_ALL] == status[0][BIT_ALL])
        else $error("normal bit 0 not the combined OR");

    a_fast_line: assert property (
        fast_request_line == $past(|status[1][DATA_W-1:1]))
        else $error("fast line not OR of status");

    a_bit0_summary: assert property (
        status[1][BIT_ALL] == (|status[1][DATA_W-1:1]) && raw[1][BIT_ALL] == status[1][BIT_ALL])
        else $error("bit 0 not the combined OR");

    a_config_hold: assert property (
        !wr_en |=> $stable(swcfg_reg))
        else $error("software config changed without a write");

    a_soft_normal: assert property (
        wr_en && wr_sel == SEL_SW_CFG |=>
        status[0][BIT_SOFT_INT] == $past(wr_data[SWCFG_NORMAL_BIT])
        && raw[0][BIT_SOFT_INT] == $past(wr_data[SWCFG_NORMAL_BIT]))
        else $error("software bit not on normal line");

    a_soft_fast: assert property (
        wr_en && wr_sel == SEL_SW_CFG |=>
        status[1][BIT_SOFT_INT] == $past(wr_data[SWCFG_FAST_BIT])
        && raw[1][BIT_SOFT_INT] == $past(wr_data[SWCFG_FAST_BIT]))
        else $error("software bit not on fast line");

    a_soft_unmasked: assert property (
        swcfg_reg[SWCFG_FAST_BIT] |=> fast_request_line)
        else $error("software interrupt masked");

    a_status_read: assert property (
        rd_en && rd_sel == SEL_NORMAL_STA |=> rd_data == $past(status[0]))
        else $error("status read wrong");

    a_fast_status_read: assert property (
        rd_en && rd_sel == SEL_FAST_STA |=> rd_data == $past(status[1]))
        else $error("fast status read wrong");

    a_normal_raw_read: assert property (
        rd_en && rd_sel == SEL_NORMAL_RAW |=> rd_data == $past(raw[0]))
        else $error("normal raw read wrong");

    a_fast_raw_read: assert property (
        rd_en && rd_sel == SEL_FAST_RAW |=> rd_data == $past(raw[1]))
        else $error("fast raw read wrong");

    a_normal_en_read: assert property (
        rd_en && rd_sel == SEL_NORMAL_EN |=> rd_data == $past(mask[0]))
        else $error("normal enable read wrong");

    a_fast_en_read: assert property (
        rd_en && rd_sel == SEL_FAST_EN |=> rd_data == $past(mask[1]))
        else $error("fast enable read wrong");

    a_config_read: assert property (
        rd_en && rd_sel == SEL_SW_CFG |=> rd_data == $past(swcfg_reg))
        else $error("software config read wrong");

    a_clear_reads_zero: assert property (
        rd_en && rd_sel == SEL_FAST_CLR |=> rd_data == '0)
        else $error("write-only register not zero");

    a_normal_clr_read: assert property (
        rd_en && rd_sel == SEL_NORMAL_CLR |=> rd_data == '0)
        else $error("normal clear register not zero");

    a_read_data_idle: assert property (
        !rd_en |=> rd_data == '0)
        else $error("read data not zero outside a read");

    c_normal_rise: cover property (!normal_request_line ##1 normal_request_line);
    c_fast_rise: cover property (!fast_request_line ##1 fast_request_line);
    c_soft_both: cover property (status[0][BIT_SOFT_INT] && status[1][BIT_SOFT_INT]);
    c_move_line: cover property (mask[0][BIT_WAKEUP] ##1 mask[1][BIT_WAKEUP]);
    c_pin_fast: cover property (fast_request_line && status[1][BIT_XPIN0]);

endmodule : dlic_top

//--- rtl/dlic_pkg.sv
// Constants and types shared by the dual-line interrupt controller
package dlic_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned LINES = 2;

    localparam logic [7:0] OFF_NORMAL_RAW = 8'h00;
    localparam logic [7:0] OFF_NORMAL_EN = 8'h04;
    localparam logic [7:0] OFF_NORMAL_CLR = 8'h08;
    localparam logic [7:0] OFF_NORMAL_STA = 8'h0c;
    localparam logic [7:0] OFF_FAST_RAW = 8'h10;
    localparam logic [7:0] OFF_FAST_EN = 8'h14;
    localparam logic [7:0] OFF_FAST_CLR = 8'h18;
    localparam logic [7:0] OFF_FAST_STA = 8'h1c;
    localparam logic [7:0] OFF_SW_CFG = 8'h20;

    localparam int unsigned BIT_ALL = 0;
    localparam int unsigned BIT_SOFT_INT = 1;
    localparam int unsigned SRC_LO = 2;
    localparam int unsigned SRC_HI = 24;
    localparam int unsigned BIT_TIMER0 = 2;
    localparam int unsigned BIT_WAKEUP = 4;
    localparam int unsigned BIT_WATCHDOG = 5;
    localparam int unsigned BIT_XPIN0 = 15;
    localparam int unsigned BIT_SUPPLY = 17;
    localparam int unsigned BIT_XPIN1 = 18;
    localparam int unsigned BIT_LOGIC0 = 19;
    localparam int unsigned BIT_LOGIC1 = 20;
    localparam int unsigned BIT_PWM_SYNC = 24;

    localparam int unsigned SWCFG_NORMAL_BIT = 1;
    localparam int unsigned SWCFG_FAST_BIT = 2;

    localparam logic [31:0] SRC_MASK = 32'h01ff_fffc;
    localparam logic [31:0] SWCFG_MASK = 32'h0000_0006;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] SWCFG_RST = 32'h0000_0000;
    localparam logic [31:0] SRC_RST = 32'h0000_0000;
    localparam logic [31:0] RD_RST = 32'h0000_0000;

    typedef enum {
        SEL_NORMAL_RAW, SEL_NORMAL_EN, SEL_NORMAL_CLR, SEL_NORMAL_STA,
        SEL_FAST_RAW, SEL_FAST_EN, SEL_FAST_CLR, SEL_FAST_STA,
        SEL_SW_CFG, SEL_NONE
    } dlic_sel_type;

endpackage : dlic_pkg

//--- rtl/dlic_mask_bank.sv
// Enable mask of one request line with set, clear and cross-clear
module dlic_mask_bank (
    input wire logic clk,
    input wire logic srst,
    input wire logic set_we,
    input wire logic clr_we,
    input wire logic cross_we,
    input wire logic [dlic_pkg::DATA_W-1:0] wr_data,
    output logic [dlic_pkg::DATA_W-1:0] mask_reg
);
    import dlic_pkg::*;

    logic [DATA_W-1:0] mask_next;

    always_comb begin
        mask_next = mask_reg;
        if (set_we) begin
            // Only real sources; bits 0 and 1 stay zero
            mask_next = mask_next | (wr_data & SRC_MASK);
        end
        if (clr_we) begin
            mask_next = mask_next & ~wr_data;
        end
        if (cross_we) begin
            // Other line took these sources
            mask_next = mask_next & ~wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

endmodule : dlic_mask_bank

//--- rtl/dlic_line_status.sv
// Raw, enabled status and request of one request line
module dlic_line_status (
    input wire logic clk,
    input wire logic srst,
    input wire logic [dlic_pkg::DATA_W-1:0] src,
    input wire logic soft_int,
    input wire logic [dlic_pkg::DATA_W-1:0] mask,
    output logic [dlic_pkg::DATA_W-1:0] raw,
    output logic [dlic_pkg::DATA_W-1:0] status,
    output logic request_reg
);
    import dlic_pkg::*;

    logic [DATA_W-1:0] active;
    logic any_active;

    always_comb begin
        active = src & mask & SRC_MASK;
        active[BIT_SOFT_INT] = soft_int;
        any_active = |active[DATA_W-1:1];
        raw = src & SRC_MASK;
        raw[BIT_SOFT_INT] = soft_int;
        raw[BIT_ALL] = any_active;
        status = active;
        status[BIT_ALL] = any_active;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            request_reg <= 1'b0;
        end else begin
            request_reg <= any_active;
        end
    end

endmodule : dlic_line_status

//--- tb/dlic_core_model.sv
// Processor core model counting normal and fast exception entries
module dlic_core_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic normal_request_line,
    input wire logic fast_request_line,
    output logic [15:0] normal_entries,
    output logic [15:0] fast_entries
);
    timeunit 1ns;
    timeprecision 1ps;

    logic normal_seen_reg;
    logic fast_seen_reg;

    // Each rise of a request level is one exception entry
    always_ff @(posedge clk) begin
        if (srst) begin
            normal_seen_reg <= 1'b0;
            normal_entries <= 16'h0000;
        end else begin
            normal_seen_reg <= normal_request_line;
            if (normal_request_line && !normal_seen_reg) begin
                normal_entries <= normal_entries + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fast_seen_reg <= 1'b0;
            fast_entries <= 16'h0000;
        end else begin
            fast_seen_reg <= fast_request_line;
            if (fast_request_line && !fast_seen_reg) begin
                fast_entries <= fast_entries + 16'h0001;
            end
        end
    end
endmodule : dlic_core_model

//--- tb/tb.sv
// Self-checking bench for the dual-line interrupt controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dlic_pkg::*;

    logic clk, srst, wr_en, rd_en, pin0, pin1, nrl, frl;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data, src_vec;
    logic [24:2] irq;
    logic [15:0] n_entries, f_entries;
    int n_mismatch, comparisons, cycles;

    dlic_top u_dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .peripheral_irq(irq), .external_request_pin_zero(pin0),
        .external_request_pin_one(pin1), .normal_request_line(nrl), .fast_request_line(frl));

    dlic_core_model u_core (.clk(clk), .srst(srst), .normal_request_line(nrl), .fast_request_line(frl),
        .normal_entries(n_entries), .fast_entries(f_entries));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(name, exp, rd_data);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic lines(input logic n, input logic f);
        chk("normal_request_line", {31'h0, n}, {31'h0, nrl});
        chk("fast_request_line", {31'h0, f}, {31'h0, frl});
    endtask : lines

    initial begin
        srst = 1'b1;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        irq = '0;
        pin0 = 1'b0;
        pin1 = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        // Every offset including clear registers and one unmapped place
        for (int k = 0; k < 10; k++) rd(8'(4 * k), "reset_value", 32'h0);
        lines(1'b0, 1'b0);
        wr(OFF_NORMAL_EN, 32'hffff_ffff);
        rd(OFF_NORMAL_EN, "normal_enable_mask", SRC_MASK);
        wr(OFF_FAST_EN, 32'h0000_0004);
        rd(OFF_FAST_EN, "fast_enable_mask", 32'h0000_0004);
        rd(OFF_NORMAL_EN, "normal_enable_mask", SRC_MASK & ~32'h4);
        wr(OFF_NORMAL_EN, 32'h0000_0004);
        rd(OFF_FAST_EN, "fast_enable_mask", 32'h0);
        wr(OFF_NORMAL_CLR, 32'h0000_0012);
        rd(OFF_NORMAL_EN, "normal_enable_mask", SRC_MASK & ~32'h10);
        wr(OFF_NORMAL_RAW, 32'hffff_ffff);
        rd(OFF_NORMAL_RAW, "normal_raw_source_signal", 32'h0);
        wr(OFF_NORMAL_EN, 32'h0000_0010);
        // Each source alone, held well past the sampling latency
        for (int i = SRC_LO; i <= SRC_HI; i++) begin
            src_vec = 32'h1 << i;
            @(posedge clk);
            irq <= src_vec[24:2];
            settle;
            rd(OFF_NORMAL_RAW, "normal_raw_source_signal", src_vec | 32'h1);
            rd(OFF_NORMAL_STA, "normal_enabled_status", src_vec | 32'h1);
            rd(OFF_FAST_RAW, "fast_raw_source_signal", src_vec);
            rd(OFF_FAST_STA, "fast_enabled_status", 32'h0);
            lines(1'b1, 1'b0);
        end
        @(posedge clk);
        irq <= '0;
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        wr(OFF_FAST_EN, 32'h0000_8000);
        settle;
        rd(OFF_FAST_STA, "fast_enabled_status", 32'h0000_8001);
        rd(OFF_NORMAL_STA, "normal_enabled_status", 32'h0004_0001);
        rd(OFF_FAST_RAW, "fast_raw_source_signal", 32'h0004_8001);
        lines(1'b1, 1'b1);
        wr(OFF_NORMAL_CLR, 32'hffff_ffff);
        wr(OFF_FAST_CLR, 32'hffff_ffff);
        settle;
        lines(1'b0, 1'b0);
        rd(OFF_NORMAL_RAW, "normal_raw_source_signal", 32'h0004_8000);
        rd(OFF_FAST_EN, "fast_enable_mask", 32'h0);
        @(posedge clk);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        wr(OFF_SW_CFG, 32'hffff_ffff);
        rd(OFF_SW_CFG, "software_interrupt_config", SWCFG_MASK);
        settle;
        rd(OFF_NORMAL_STA, "normal_enabled_status", 32'h3);
        rd(OFF_FAST_STA, "fast_enabled_status", 32'h3);
        rd(OFF_NORMAL_RAW, "normal_raw_source_signal", 32'h3);
        lines(1'b1, 1'b1);
        wr(OFF_SW_CFG, 32'h0000_0004);
        wr(OFF_FAST_CLR, 32'h0000_0002);
        settle;
        rd(OFF_NORMAL_STA, "normal_enabled_status", 32'h0);
        rd(OFF_FAST_RAW, "fast_raw_source_signal", 32'h3);
        lines(1'b0, 1'b1);
        wr(OFF_SW_CFG, 32'h0);
        settle;
        lines(1'b0, 1'b0);
        chk("normal_entries", 32'h2, {16'h0, n_entries});
        chk("fast_entries", 32'h2, {16'h0, f_entries});
        wrap_up;
    end
endmodule : tb
